// file: host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wake_pin_i,
  input wire logic respond_i,
  input wire logic [7:0] delay_i,
  input wire logic raise_i,
  input wire logic drop_i,
  output logic host_power_request_o
);
  logic [7:0] wait_cnt;
  // ------------------------------------------------------------
  // Host answer to the wake line
  // ------------------------------------------------------------
  // Slow answers model a busy host; respond_i low models a dead one
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 8'h00;
      host_power_request_o <= 1'b0;
    end else if (drop_i) begin
      wait_cnt <= 8'h00;
      host_power_request_o <= 1'b0;
    end else if (raise_i) begin
      host_power_request_o <= 1'b1;
    end else if (!wake_pin_i && !host_power_request_o) begin
      wait_cnt <= wait_cnt + 8'h01;
      if (respond_i && wait_cnt >= delay_i) begin
        host_power_request_o <= 1'b1;
      end
    end else begin
      wait_cnt <= 8'h00;
    end
  end
endmodule

// file: pmic_pkg.sv
package pmic_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWR_REQ_TIMEOUT_MS = 5000;
  localparam int SLEEP_DELAY_MS = 1000;
  localparam int RESET_MIN_MS = 1000;
  localparam int PB_RESET_MS = 8000;
  localparam int MIN_OFF_MS = 100;
  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] RAIL_ADDR = 8'h04;
  localparam logic [7:0] SLOT_ADDR = 8'h08;
  localparam logic [7:0] VOLT_ADDR = 8'h0C;
  localparam logic [7:0] SWCFG_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;
  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam int CTRL_FOLLOW_BIT = 1;
  localparam int CTRL_CHARGE_BIT = 2;
  localparam int VOLT_A_LSB = 0;
  localparam int VOLT_B_LSB = 8;
  localparam int VOLT_CORE_LSB = 16;
  localparam int VOLT_W = 6;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_TIMEOUT_BIT = 4;
  localparam int STAT_WAKEMEM_BIT = 5;
  localparam int NUM_RAILS = 5;
  localparam int SLOT_W = 4;
  localparam int RAIL_CORE = 2;
  localparam logic [SLOT_W-1:0] SLOT_SEQ_FIRST = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_SEQ_LAST = 4'h6;
  localparam logic [2:0] STEP_TOP = 3'h7;
  localparam logic [NUM_RAILS*SLOT_W-1:0] SLOTS_RESET = 20'h4312F;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h0, ST_WAIT = 3'h1, ST_ACTIVE = 3'h3,
    ST_PWRDN = 3'h2, ST_SLEEP = 3'h6, ST_RESET = 3'h7
  } pstate_t;
  typedef struct packed {
    logic load_switch_b; logic load_switch_a; logic core_buck_converter;
    logic standby_regulator_b; logic standby_regulator_a;
  } rails_t;
  typedef struct packed {
    logic [7:0] paddr; logic psel; logic penable; logic pwrite; logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {logic [31:0] prdata; logic pready; logic pslverr;} apb_rsp_t;
  typedef struct packed {
    logic shutdown_sel; logic core_follow; logic charge_en; logic [1:0] sw_mode;
    logic [NUM_RAILS*SLOT_W-1:0] slots;
    logic [VOLT_W-1:0] core_v; logic [VOLT_W-1:0] reg_b_v; logic [VOLT_W-1:0] reg_a_v;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{shutdown_sel: 1'b0, core_follow: 1'b0, charge_en: 1'b1,
    sw_mode: 2'h0, slots: SLOTS_RESET, core_v: 6'h0C, reg_b_v: 6'h06, reg_a_v: 6'h09};
  typedef struct packed {
    pstate_t state; logic [15:0] tick_cnt; logic tick; logic [13:0] ms_cnt;
    logic [13:0] pb_cnt; logic [2:0] step; logic [2:0] sy1; logic [2:0] sy2;
    logic [2:0] sy3; logic fault_latched; logic timeout_flag; logic wake_mem;
    logic notify_oe; logic [NUM_RAILS-1:0] rails; logic charger_on; logic osc_en;
    logic [VOLT_W-1:0] reg_b_set; cfg_t cfg; apb_rsp_t rsp;
  } ctl_t;
  localparam ctl_t CTL_RESET = '{state: ST_OFF, sy1: 3'h1, sy2: 3'h1, sy3: 3'h1,
    notify_oe: 1'b1, reg_b_set: 6'h06, cfg: CFG_RESET, default: '0};
endpackage

// file: pmic_power_state_controller.sv
`timescale 1ns/1ns
// Functional notes
// - OFF keeps rails off, defaults, bus disabled
// - Leave OFF only on a wake event
// - Shutdown bit set plus request low gives OFF
// - Faults or request timeout force OFF
// - After fault, wait clear then fresh wake
// - Wake enables unslotted rails, pulls notify low
// - Request within 5 s, else OFF
// - ACTIVE entry starts power-up sequencer
// - Notify released once request is asserted
// - SLEEP exits on wake or request high
// - Shutdown bit clear: power-down, SLEEP after 1 s
// - SLEEP keeps unsequenced rails as they were
// - SLEEP entry restores all settings
// - Charger runs in SLEEP while supply present
// - Follow bit takes core buck voltage field
// - Regulators driven by slot or enable bit
// - Regulator A defaults to special slot 15
// - Slots writable only in ACTIVE, reset on SLEEP, OFF or RESET entry
// - Switches by sequencer or enable, mode bit
// - Oscillator runs with core buck on, charger on, or supply present outside OFF
// - Fault monitoring everywhere except OFF
// - Supply edge in min-off wait is remembered
// - Hardware reset: rails off, defaults, 1 s hold
// - Button held low resets every 8 s
module pmic_power_state_controller #(
  parameter int TICK_CYCLES = pmic_pkg::TICK_CYCLES,
  parameter int PWR_REQ_MS = pmic_pkg::PWR_REQ_TIMEOUT_MS,
  parameter int SLEEP_MS = pmic_pkg::SLEEP_DELAY_MS,
  parameter int RESET_MS = pmic_pkg::RESET_MIN_MS,
  parameter int PB_HOLD_MS = pmic_pkg::PB_RESET_MS,
  parameter int MIN_OFF_WAIT_MS = pmic_pkg::MIN_OFF_MS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pmic_pkg::apb_req_t apb_i,
  output pmic_pkg::apb_rsp_t apb_o,
  input wire logic push_button_in_i,
  input wire logic usb_present_i,
  input wire logic adapter_present_i,
  input wire logic host_power_request_i,
  input wire logic hw_reset_in_n_i,
  input wire logic overtemp_shutdown_i,
  input wire logic power_good_fail_i,
  input wire logic uvlo_i,
  output pmic_pkg::rails_t rails_o,
  output logic [5:0] standby_reg_a_voltage_o,
  output logic [5:0] standby_reg_b_setpoint_o,
  output logic [5:0] core_buck_voltage_o,
  output logic switch_a_regulator_mode_o,
  output logic switch_b_regulator_mode_o,
  output logic charger_on_o,
  output logic osc_en_o,
  output logic wake_notify_out_o,
  output logic wake_notify_oe_o
);
  import pmic_pkg::*;

  ctl_t s;
  ctl_t n;
  logic [NUM_RAILS-1:0] seq_slot;
  logic [NUM_RAILS-1:0] free_slot;
  logic [NUM_RAILS-1:0] up_hit;
  logic [NUM_RAILS-1:0] down_hit;
  logic fault_any;
  logic wake_ev;
  logic pb_low;
  logic pb_expire;
  logic supply;
  logic [31:0] rdata;
  logic mapped;
  logic wr;

  // ------------------------------------------------------------
  // Per-rail slot decode
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
    logic [SLOT_W-1:0] slot;
    assign slot = s.cfg.slots[i*SLOT_W +: SLOT_W];
    // Slots 14 and 15 fall outside the sequenced range on purpose
    assign seq_slot[i] = (slot >= SLOT_SEQ_FIRST) && (slot <= SLOT_SEQ_LAST);
    assign free_slot[i] = !seq_slot[i];
    assign up_hit[i] = seq_slot[i] && (slot <= {1'b0, s.step});
    assign down_hit[i] = seq_slot[i] && (slot >= {1'b0, s.step});
  end

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  // Only the second and third sync stages are looked at
  assign pb_low = !s.sy2[0];
  assign wake_ev = (!s.sy2[0] && s.sy3[0]) || (s.sy2[1] && !s.sy3[1])
                   || (s.sy2[2] && !s.sy3[2]);
  assign fault_any = overtemp_shutdown_i || power_good_fail_i || uvlo_i;
  assign pb_expire = pb_low && s.tick && (s.pb_cnt == 14'(PB_HOLD_MS - 1));
  assign supply = s.sy2[1] || s.sy2[2];

  // ------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------
  always_comb begin
    rdata = 32'h0;
    mapped = 1'b1;
    case (apb_i.paddr)
      CTRL_ADDR: begin
        rdata[CTRL_SHUTDOWN_BIT] = s.cfg.shutdown_sel;
        rdata[CTRL_FOLLOW_BIT] = s.cfg.core_follow;
        rdata[CTRL_CHARGE_BIT] = s.cfg.charge_en;
      end
      RAIL_ADDR: rdata[NUM_RAILS-1:0] = s.rails;
      SLOT_ADDR: rdata[NUM_RAILS*SLOT_W-1:0] = s.cfg.slots;
      VOLT_ADDR: begin
        rdata[VOLT_A_LSB +: VOLT_W] = s.cfg.reg_a_v;
        rdata[VOLT_B_LSB +: VOLT_W] = s.cfg.reg_b_v;
        rdata[VOLT_CORE_LSB +: VOLT_W] = s.cfg.core_v;
      end
      SWCFG_ADDR: rdata[1:0] = s.cfg.sw_mode;
      STATUS_ADDR: begin
        rdata[2:0] = s.state;
        rdata[STAT_FAULT_BIT] = s.fault_latched;
        rdata[STAT_TIMEOUT_BIT] = s.timeout_flag;
        rdata[STAT_WAKEMEM_BIT] = s.wake_mem;
      end
      default: mapped = 1'b0;
    endcase
  end

  // A setup granted just before a fault must not write into the OFF defaults
  assign wr = apb_i.psel && apb_i.penable && s.rsp.pready && apb_i.pwrite
              && !s.rsp.pslverr && (s.state != ST_OFF);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    // Millisecond tick from a prescaler stands in for the oscillator
    n.tick = 1'b0;
    if (s.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 16'h1;
    end
    if (s.tick && (s.ms_cnt != 14'h3FFF)) begin
      n.ms_cnt = s.ms_cnt + 14'h1;
    end
    n.sy1 = {adapter_present_i, usb_present_i, push_button_in_i};
    n.sy2 = s.sy1;
    n.sy3 = s.sy2;
    if (!pb_low || pb_expire) begin
      n.pb_cnt = '0;
    end else if (s.tick) begin
      n.pb_cnt = s.pb_cnt + 14'h1;
    end

    // Bus: a setup cycle is answered in the next cycle, no wait states
    n.rsp.pready = 1'b0;
    if (apb_i.psel && !apb_i.penable) begin
      n.rsp.pready = 1'b1;
      n.rsp.pslverr = (s.state == ST_OFF) || !mapped;
      n.rsp.prdata = (s.state == ST_OFF) ? 32'h0 : rdata;
    end
    if (wr) begin
      case (apb_i.paddr)
        CTRL_ADDR: begin
          n.cfg.shutdown_sel = apb_i.pwdata[CTRL_SHUTDOWN_BIT];
          n.cfg.core_follow = apb_i.pwdata[CTRL_FOLLOW_BIT];
          n.cfg.charge_en = apb_i.pwdata[CTRL_CHARGE_BIT];
        end
        RAIL_ADDR: n.rails = apb_i.pwdata[NUM_RAILS-1:0];
        SLOT_ADDR: begin
          if (s.state == ST_ACTIVE) begin
            n.cfg.slots = apb_i.pwdata[NUM_RAILS*SLOT_W-1:0];
          end
        end
        VOLT_ADDR: begin
          n.cfg.reg_a_v = apb_i.pwdata[VOLT_A_LSB +: VOLT_W];
          n.cfg.reg_b_v = apb_i.pwdata[VOLT_B_LSB +: VOLT_W];
          n.cfg.core_v = apb_i.pwdata[VOLT_CORE_LSB +: VOLT_W];
        end
        SWCFG_ADDR: n.cfg.sw_mode = apb_i.pwdata[1:0];
        STATUS_ADDR: begin
          if (apb_i.pwdata[STAT_TIMEOUT_BIT]) begin
            n.timeout_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    unique case (s.state)
      ST_OFF: begin
        if (!fault_any) begin
          n.fault_latched = 1'b0;
        end
        // The latch still stands this cycle, so the clearing cycle's wake is ignored
        if (wake_ev && !s.fault_latched && !fault_any) begin
          n.state = ST_WAIT;
          n.rails = s.rails | free_slot;
          n.notify_oe = 1'b0;
        end
      end
      ST_WAIT: begin
        if (host_power_request_i) begin
          n.state = ST_ACTIVE;
          n.notify_oe = 1'b1;
          n.step = '0;
        end else if (s.ms_cnt >= 14'(PWR_REQ_MS)) begin
          n.state = ST_OFF;
          n.timeout_flag = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (s.tick && (s.step != STEP_TOP)) begin
          n.rails = n.rails | up_hit;
          n.step = s.step + 3'h1;
        end
        if (!host_power_request_i) begin
          if (s.cfg.shutdown_sel) begin
            n.state = ST_OFF;
          end else begin
            n.state = ST_PWRDN;
            n.step = STEP_TOP;
          end
        end
      end
      ST_PWRDN: begin
        // Only sequenced rails go down; the rest keep state
        if (s.tick && (s.step != 3'h0)) begin
          n.rails = n.rails & ~down_hit;
          n.step = s.step - 3'h1;
        end
        if (s.ms_cnt >= 14'(SLEEP_MS)) begin
          n.state = ST_SLEEP;
          n.cfg = CFG_RESET;
          n.wake_mem = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (host_power_request_i) begin
          n.state = ST_ACTIVE;
          n.step = '0;
        end else if (s.ms_cnt < 14'(MIN_OFF_WAIT_MS)) begin
          if (wake_ev) begin
            n.wake_mem = 1'b1;
          end
        end else if (wake_ev || s.wake_mem) begin
          n.state = ST_WAIT;
          n.wake_mem = 1'b0;
          n.notify_oe = 1'b0;
          n.rails = n.rails | free_slot;
        end
      end
      ST_RESET: begin
        if (hw_reset_in_n_i && (s.ms_cnt >= 14'(RESET_MS))) begin
          n.state = ST_WAIT;
          n.notify_oe = 1'b0;
          n.rails = free_slot;
        end
      end
    endcase

    // Hardware reset or a long button press power-cycles the rails
    if ((s.state != ST_OFF) && (s.state != ST_RESET) && (!hw_reset_in_n_i || pb_expire)) begin
      n.state = ST_RESET;
    end
    if ((s.state != ST_OFF) && fault_any) begin
      n.state = ST_OFF;
      n.fault_latched = 1'b1;
    end
    if ((n.state == ST_OFF || n.state == ST_RESET) && n.state != s.state) begin
      n.rails = '0;
      n.cfg = CFG_RESET;
      n.notify_oe = 1'b1;
      n.wake_mem = 1'b0;
    end
    if (n.state != s.state) begin
      n.ms_cnt = '0;
    end

    // Registered outputs derived from the settled next values
    // Use the next synchronised supply bits so the charger never lags a supply change
    n.charger_on = (n.sy2[1] || n.sy2[2]) && (n.state != ST_OFF)
                   && ((n.state == ST_SLEEP) || n.cfg.charge_en);
    n.osc_en = n.rails[RAIL_CORE] || n.charger_on
               || ((n.sy2[1] || n.sy2[2]) && (n.state != ST_OFF));
    n.reg_b_set = n.cfg.core_follow ? n.cfg.core_v : n.cfg.reg_b_v;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= CTL_RESET;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign apb_o = s.rsp;
  assign rails_o = rails_t'(s.rails);
  assign standby_reg_a_voltage_o = s.cfg.reg_a_v;
  assign standby_reg_b_setpoint_o = s.reg_b_set;
  assign core_buck_voltage_o = s.cfg.core_v;
  assign switch_a_regulator_mode_o = s.cfg.sw_mode[0];
  assign switch_b_regulator_mode_o = s.cfg.sw_mode[1];
  assign charger_on_o = s.charger_on;
  assign osc_en_o = s.osc_en;
  // Open-drain: the pin only ever pulls low
  assign wake_notify_out_o = 1'b0;
  assign wake_notify_oe_o = s.notify_oe;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_off_quiet;
    s.state == ST_OFF |-> (s.rails == '0) && (s.cfg == CFG_RESET) && s.notify_oe;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("OFF not quiet");

  property p_off_bus;
    (s.state == ST_OFF) && apb_i.psel && !apb_i.penable |=> s.rsp.pready && s.rsp.pslverr;
  endproperty
  a_off_bus: assert property (p_off_bus) else $error("bus live in OFF");

  property p_stay_off;
    (s.state == ST_OFF) && !wake_ev |=> s.state == ST_OFF;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("OFF left without wake");

  property p_fault_off;
    (s.state != ST_OFF) && fault_any |=> (s.state == ST_OFF) && (s.rails == '0)
      && s.fault_latched;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not shut down");

  property p_fault_hold;
    (s.state == ST_OFF) && s.fault_latched |=> s.state == ST_OFF;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("OFF left while latched");

  property p_wake;
    (s.state == ST_OFF) && wake_ev && !s.fault_latched && !fault_any
      |=> (s.state == ST_WAIT) && !s.notify_oe && ((s.rails & free_slot) == free_slot);
  endproperty
  a_wake: assert property (p_wake) else $error("wake handling wrong");

  property p_timeout;
    (s.state == ST_WAIT) && !host_power_request_i && (s.ms_cnt >= 14'(PWR_REQ_MS))
      && !fault_any && hw_reset_in_n_i && !pb_expire |=> (s.state == ST_OFF) && s.timeout_flag;
  endproperty
  a_timeout: assert property (p_timeout) else $error("request timeout missed");

  property p_release;
    (s.state == ST_WAIT) && host_power_request_i && !fault_any && hw_reset_in_n_i && !pb_expire
      |=> (s.state == ST_ACTIVE) && s.notify_oe && (s.step == 3'h0);
  endproperty
  a_release: assert property (p_release) else $error("notify not released");

  property p_sleep_entry;
    (s.state == ST_PWRDN) ##1 (s.state == ST_SLEEP)
      |-> ($past(s.ms_cnt) >= 14'(SLEEP_MS)) && (s.cfg == CFG_RESET) && !s.wake_mem;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_follow;
    s.cfg.core_follow && (s.state != ST_OFF) |-> s.reg_b_set == s.cfg.core_v;
  endproperty
  a_follow: assert property (p_follow) else $error("tracking setpoint wrong");

  property p_charge_sleep;
    s.state == ST_SLEEP |-> s.charger_on == supply;
  endproperty
  a_charge_sleep: assert property (p_charge_sleep) else $error("sleep charger wrong");

  c_active: cover property ((s.state == ST_WAIT) ##1 (s.state == ST_ACTIVE));
  c_sleep: cover property ((s.state == ST_PWRDN) ##1 (s.state == ST_SLEEP));
  c_reset: cover property ((s.state == ST_RESET) ##1 (s.state == ST_WAIT));
  c_timeout: cover property ((s.state == ST_WAIT) ##1 (s.state == ST_OFF));
endmodule

// file: tb.sv
`timescale 1ns/1ns
module tb;
  import pmic_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  apb_req_t apb_i = '0;
  apb_rsp_t apb_o;
  logic button = 1'b1;
  logic usb = 1'b0;
  logic adapter = 1'b0;
  logic uvlo = 1'b0;
  logic respond = 1'b1;
  logic raise = 1'b0;
  logic drop = 1'b0;
  logic [7:0] delay = 8'h28;
  logic overtemp = 1'b0;
  logic pgood_fail = 1'b0;
  logic hw_reset_n = 1'b1;
  logic request;
  rails_t rails;
  logic [5:0] reg_a_v, reg_b_v, core_v;
  logic mode_a, mode_b, charger_on, osc_en, notify_val, notify_oe;
  // Open-drain wake line with pull-up
  wire logic wake_pin = notify_oe ? 1'b1 : notify_val;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;

  always #20 mclk_i = ~mclk_i;

  pmic_power_state_controller #(.TICK_CYCLES(4), .PWR_REQ_MS(20), .SLEEP_MS(10),
    .RESET_MS(10), .PB_HOLD_MS(30)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
    .push_button_in_i(button), .usb_present_i(usb), .adapter_present_i(adapter),
    .host_power_request_i(request), .hw_reset_in_n_i(hw_reset_n),
    .overtemp_shutdown_i(overtemp), .power_good_fail_i(pgood_fail), .uvlo_i(uvlo),
    .rails_o(rails),
    .standby_reg_a_voltage_o(reg_a_v), .standby_reg_b_setpoint_o(reg_b_v),
    .core_buck_voltage_o(core_v), .switch_a_regulator_mode_o(mode_a),
    .switch_b_regulator_mode_o(mode_b), .charger_on_o(charger_on), .osc_en_o(osc_en),
    .wake_notify_out_o(notify_val), .wake_notify_oe_o(notify_oe));

  host_model host (.mclk_i(mclk_i), .rst_i(rst_i), .wake_pin_i(wake_pin),
    .respond_i(respond), .delay_i(delay), .raise_i(raise), .drop_i(drop),
    .host_power_request_o(request));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge mclk_i);
    apb_i <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
    @(posedge mclk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
    // Outputs launched by the access edge are only settled one edge later
    @(posedge mclk_i);
  endtask

  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      if (rd[2:0] === s) begin
        break;
      end
    end
    check("state", 32'(rd[2:0]), 32'(s));
  endtask

  task automatic pulse(input bit up);
    @(posedge mclk_i);
    raise <= up;
    drop <= !up;
    @(posedge mclk_i);
    raise <= 1'b0;
    drop <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check("rails_off", 32'(rails), 32'h0);
    check("osc_off", 32'(osc_en), 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("bus_off", 32'(err), 32'h1);
    usb <= 1'b1;
    repeat (6) @(posedge mclk_i);
    check("notify_low", 32'(notify_oe), 32'h0);
    check("notify_pin", 32'(wake_pin), 32'h0);
    check("unslotted", 32'(rails), 32'h01);
    wait_state(ST_ACTIVE);
    check("notify_rel", 32'(notify_oe), 32'h1);
    repeat (40) @(posedge mclk_i);
    check("all_rails", 32'(rails), 32'h1F);
    check("osc_on", 32'(osc_en), 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h6);
    apb(1'b1, VOLT_ADDR, 32'h00150A0B);
    check("follow", 32'(reg_b_v), 32'h15);
    check("core_v", 32'(core_v), 32'h15);
    apb(1'b1, SWCFG_ADDR, 32'h3);
    check("mode_a", 32'(mode_a), 32'h1);
    check("mode_b", 32'(mode_b), 32'h1);
    apb(1'b1, SLOT_ADDR, 32'h0004312E);
    apb(1'b0, SLOT_ADDR, 32'h0);
    check("slot_wr", rd, 32'h0004312E);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    pulse(1'b0);
    wait_state(ST_SLEEP);
    check("sleep_rails", 32'(rails), 32'h01);
    apb(1'b0, VOLT_ADDR, 32'h0);
    check("volt_def", rd, 32'h000C0609);
    check("setpt_def", 32'(reg_b_v), 32'h06);
    check("reg_a_def", 32'(reg_a_v), 32'h09);
    check("mode_def", 32'(mode_a), 32'h0);
    check("charger", 32'(charger_on), 32'h1);
    pulse(1'b1);
    wait_state(ST_ACTIVE);
    apb(1'b0, SLOT_ADDR, 32'h0);
    check("slot_def", rd, 32'h0004312F);
    apb(1'b1, CTRL_ADDR, 32'h5);
    pulse(1'b0);
    repeat (3) @(posedge mclk_i);
    check("off_rails", 32'(rails), 32'h0);
    // Fault shutdown, then a wake refused while the fault persists
    adapter <= 1'b1;
    repeat (6) @(posedge mclk_i);
    check("wake_ac", 32'(notify_oe), 32'h0);
    wait_state(ST_ACTIVE);
    uvlo <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("fault_off", 32'(rails), 32'h0);
    pulse(1'b0);
    button <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check("fault_hold", 32'(notify_oe), 32'h1);
    button <= 1'b1;
    uvlo <= 1'b0;
    respond <= 1'b0;
    repeat (6) @(posedge mclk_i);
    button <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check("fresh_wake", 32'(notify_oe), 32'h0);
    button <= 1'b1;
    repeat (90) @(posedge mclk_i);
    check("timeout", 32'(notify_oe), 32'h1);
    check("timeout_rails", 32'(rails), 32'h0);
    // Other fault sources, then the hardware reset and the long button press
    respond <= 1'b1;
    delay <= 8'h08;
    button <= 1'b0;
    wait_state(ST_ACTIVE);
    button <= 1'b1;
    overtemp <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("ots_off", 32'(rails), 32'h0);
    overtemp <= 1'b0;
    respond <= 1'b0;
    pulse(1'b0);
    button <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check("pg_wait", 32'(notify_oe), 32'h0);
    pgood_fail <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("pg_off", 32'(notify_oe), 32'h1);
    check("pg_rails", 32'(rails), 32'h0);
    pgood_fail <= 1'b0;
    button <= 1'b1;
    respond <= 1'b1;
    repeat (3) @(posedge mclk_i);
    button <= 1'b0;
    wait_state(ST_ACTIVE);
    button <= 1'b1;
    hw_reset_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    hw_reset_n <= 1'b1;
    repeat (20) @(posedge mclk_i);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check("rst_hold", 32'(rd[2:0]), 32'(ST_RESET));
    check("rst_rails", 32'(rails), 32'h0);
    wait_state(ST_ACTIVE);
    button <= 1'b0;
    wait_state(ST_RESET);
    button <= 1'b1;
    wait_state(ST_ACTIVE);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    summarize();
  end
endmodule
